// file: hw/mcaux_top.sv
// Auxiliary execution functions of one solenoid-controller microcore
//
// Operation
// - Four threshold DACs are locations of the internal map, read and written.
// - Value-only mode touches the value field; combined register touches high field.
// - Offset-only mode touches the offset field; combined register touches negative field.
// - Full mode reads or writes every field at once.
// - Conversion mode with value-only mode: reads of the four DACs return the conversion result.
// - Shared location carries a 16-bit word; reader selects the source core.
// - Register reset clears a chosen set and may re-arm diagnosis interrupts.
// - Diagnosis enable changes only outputs this core may drive.
// - Flag bus is 16 bits, active low, resets to all ones.
// - Four flag buses merge according to the combining configuration.
// - Unlocked core drives all its flags inactive high.
// - Interrupt instruction sets the request, which drives the low-active pin.
// - Jump to subroutine captures the program counter into the auxiliary register; a map write to it in the same cycle wins.
// - Offset compensation on first four DACs; 4-low also corrects 4-high.
// - Gain instruction changes the shunt amplifier gain.
// - Conversion instruction enters conversion mode; thresholds are not compared.
// - Status register written whole or one bit at a time.
// - Backdoor reaches every external register except code memory, data memory and the DAC registers.
// - Backdoor access takes two cycles; a read overwrites the data location at the end of its first cycle.
// - Idle backdoor address and data locations are plain storage.
// - Backdoor write to a locked register is dropped.
// - DAC and boost DAC registers are unreachable through the backdoor.
`timescale 1ns/100ps
`default_nettype none
`include "mcaux_map.svh"
module mcaux_top
    import mcaux_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire mcaux_op_e instr_op,
    input wire logic [15:0] instr_param,
    input wire logic [9:0] program_counter,
    input wire logic core_unlocked,
    input wire logic mm_wr,
    input wire logic mm_rd,
    input wire logic [7:0] mm_addr,
    input wire logic [15:0] mm_wdata,
    output logic [15:0] mm_rdata,
    input wire logic [3:0][8:0] adc_result,
    input wire logic [3:0][15:0] shared_in,
    output logic [15:0] shared_exchange_location,
    input wire logic [2:0][15:0] flags_other,
    input wire logic [3:0] flag_combine_cfg,
    output logic [15:0] own_flags_n,
    output logic [15:0] merged_flags_n,
    output logic interrupt_out_pin_n,
    output logic [9:0] aux_return,
    input wire logic [7:0] out_access,
    output logic [7:0] diag_enable,
    input wire logic [15:0] diag_event,
    output logic diag_irq_armed,
    output logic [15:0] status_bits,
    output logic [15:0] ctrl_bits,
    output logic [15:0] diag_errors,
    output logic [3:0][15:0] dac_threshold,
    output logic [15:0] dac_high_neg_combined,
    output logic [4:0] offset_comp_en,
    output logic [2:0] amp_gain,
    output logic conv_mode,
    output logic compare_en,
    output logic ext_req,
    output logic ext_wr,
    output logic [7:0] ext_addr,
    output logic [15:0] ext_wdata,
    input wire logic [15:0] ext_rdata,
    input wire logic ext_locked,
    output logic bd_busy
);

    // Mask of the fields that one access may see, for a DAC or the combined register
    function automatic logic [15:0] field_mask(input mcaux_mode_e mode, input logic combined);
        logic [15:0] m;
        m = 16'h0000;
        case (mode)
            MCAUX_MODE_VALUE: m = combined ? `MCAUX_HN_HIGH_MASK : `MCAUX_DAC_VALUE_MASK;
            MCAUX_MODE_OFFSET: m = combined ? `MCAUX_HN_NEG_MASK : `MCAUX_DAC_OFFSET_MASK;
            MCAUX_MODE_FULL: m = combined ? `MCAUX_HN_FULL_MASK : `MCAUX_DAC_FULL_MASK;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

    // Register reset variant to {status, ctrl, diag, re-arm}
    function automatic logic [3:0] reset_set(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h0;
        case (sel)
            3'h0: r = 4'h8;
            3'h1: r = 4'h4;
            3'h2: r = 4'hb;
            3'h3: r = 4'hf;
            3'h4: r = 4'h3;
            3'h5: r = 4'hc;
            3'h6: r = 4'h9;
            default: r = 4'h1;
        endcase
        return r;
    endfunction

    function automatic logic is_dac(input logic [7:0] a);
        // DAC0 sits at offset zero, so only the top bound needs a compare
        return a <= `MCAUX_ADDR_DAC3;
    endfunction

    mcaux_mode_e mode_reg;
    mcaux_bd_e bd_state_reg;
    logic [1:0] src_sel_reg;
    logic [15:0] flags_reg;
    logic irq_reg;
    logic [7:0] bd_addr_reg;
    logic [15:0] bd_data_reg;
    logic bd_wr_reg;
    logic [15:0] rd_next;
    logic [15:0] flags_merged_next;
    logic [3:0] rst_sel;
    logic [15:0] stat_bit_mask;
    logic do_op;

    assign do_op = instr_valid;
    assign rst_sel = (do_op && instr_op == MCAUX_OP_REG_RESET) ? reset_set(instr_param[2:0])
                                                                 : 4'h0;
    assign stat_bit_mask = 16'h0001 << instr_param[3:0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MCAUX_MODE_FULL;
        end else if (do_op && instr_op == MCAUX_OP_DAC_MODE) begin
            mode_reg <= mcaux_mode_e'(instr_param[1:0]);
        end
    end

    // DAC locations; writes never reach reserved bits because the mask excludes them
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dac
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    dac_threshold[gi] <= `MCAUX_DAC_RESET;
                end else if (mm_wr && mm_addr == `MCAUX_ADDR_DAC0 + 8'(gi)) begin
                    dac_threshold[gi] <= (dac_threshold[gi] & ~field_mask(mode_reg, 1'b0))
                                       | (mm_wdata & field_mask(mode_reg, 1'b0));
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dac_high_neg_combined <= `MCAUX_DAC_RESET;
        end else if (mm_wr && mm_addr == `MCAUX_ADDR_DAC4H4NEG) begin
            dac_high_neg_combined <= (dac_high_neg_combined & ~field_mask(mode_reg, 1'b1))
                                   | (mm_wdata & field_mask(mode_reg, 1'b1));
        end
    end

    // Registered read port of the internal map; unmapped addresses read zero
    always_comb begin
        rd_next = 16'h0000;
        if (is_dac(mm_addr)) begin
            if (conv_mode && mode_reg == MCAUX_MODE_VALUE) begin
                rd_next = {7'h00, adc_result[mm_addr[1:0]]} & `MCAUX_ADC_MASK;
            end else begin
                rd_next = dac_threshold[mm_addr[1:0]] & field_mask(mode_reg, 1'b0);
            end
        end else if (mm_addr == `MCAUX_ADDR_DAC4H4NEG) begin
            rd_next = dac_high_neg_combined & field_mask(mode_reg, 1'b1);
        end else if (mm_addr == `MCAUX_ADDR_SHARED) begin
            rd_next = shared_in[src_sel_reg];
        end else if (mm_addr == `MCAUX_ADDR_STATUS) begin
            rd_next = status_bits;
        end else if (mm_addr == `MCAUX_ADDR_CTRL) begin
            rd_next = ctrl_bits;
        end else if (mm_addr == `MCAUX_ADDR_BD_ADDR) begin
            rd_next = {8'h00, bd_addr_reg};
        end else if (mm_addr == `MCAUX_ADDR_BD_DATA) begin
            rd_next = bd_data_reg;
        end else if (mm_addr == `MCAUX_ADDR_AUX) begin
            rd_next = {6'h00, aux_return};
        end else if (mm_addr == `MCAUX_ADDR_DIAG) begin
            rd_next = diag_errors;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mm_rdata <= 16'h0000;
        end else if (mm_rd) begin
            mm_rdata <= rd_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shared_exchange_location <= 16'h0000;
            src_sel_reg <= 2'h0;
        end else begin
            if (mm_wr && mm_addr == `MCAUX_ADDR_SHARED) begin
                shared_exchange_location <= mm_wdata;
            end
            if (do_op && instr_op == MCAUX_OP_SHARED_SEL) begin
                src_sel_reg <= instr_param[1:0];
            end
        end
    end

    // Status: reset instruction first, then whole-word write, then single-bit set or clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_bits <= 16'h0000;
        end else if (rst_sel[3]) begin
            status_bits <= 16'h0000;
        end else if (mm_wr && mm_addr == `MCAUX_ADDR_STATUS) begin
            status_bits <= mm_wdata;
        end else if (do_op && instr_op == MCAUX_OP_STAT_BIT) begin
            status_bits <= instr_param[4] ? (status_bits | stat_bit_mask)
                                          : (status_bits & ~stat_bit_mask);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_bits <= 16'h0000;
        end else if (rst_sel[2]) begin
            ctrl_bits <= 16'h0000;
        end else if (mm_wr && mm_addr == `MCAUX_ADDR_CTRL) begin
            ctrl_bits <= mm_wdata;
        end
    end

    // A diagnosis event in the clearing cycle survives: set wins over clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_errors <= 16'h0000;
            diag_irq_armed <= 1'b1;
        end else begin
            diag_errors <= (rst_sel[1] ? 16'h0000 : diag_errors) | diag_event;
            if (rst_sel[0]) begin
                diag_irq_armed <= 1'b1;
            end else if (diag_irq_armed && |diag_event) begin
                diag_irq_armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_enable <= 8'h00;
        end else if (do_op && instr_op == MCAUX_OP_DIAG_EN) begin
            diag_enable <= (diag_enable & ~(instr_param[15:8] & out_access))
                         | (instr_param[7:0] & instr_param[15:8] & out_access);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= `MCAUX_FLAGS_RESET;
        end else if (do_op && instr_op == MCAUX_OP_FLAG) begin
            flags_reg[instr_param[3:0]] <= instr_param[4];
        end
    end

    // Active-low buses combine by AND; a disabled source counts as inactive
    always_comb begin
        flags_merged_next = flag_combine_cfg[0] ? own_flags_n : `MCAUX_FLAGS_RESET;
        for (int i = 0; i < 3; i++) begin
            if (flag_combine_cfg[i + 1]) begin
                flags_merged_next = flags_merged_next & flags_other[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            own_flags_n <= `MCAUX_FLAGS_RESET;
            merged_flags_n <= `MCAUX_FLAGS_RESET;
        end else begin
            own_flags_n <= core_unlocked ? `MCAUX_FLAGS_RESET : flags_reg;
            merged_flags_n <= flags_merged_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
            interrupt_out_pin_n <= 1'b1;
        end else begin
            if (do_op && instr_op == MCAUX_OP_IRQ) begin
                irq_reg <= instr_param[0];
            end
            interrupt_out_pin_n <= ~irq_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aux_return <= 10'h000;
        end else if (mm_wr && mm_addr == `MCAUX_ADDR_AUX) begin
            aux_return <= mm_wdata[9:0];
        end else if (do_op && instr_op == MCAUX_OP_JSR) begin
            aux_return <= program_counter;
        end
    end

    // Current measure control; the negative DAC never gets compensation
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            offset_comp_en <= 5'h00;
            amp_gain <= 3'h0;
            conv_mode <= 1'b0;
            compare_en <= 1'b1;
        end else begin
            if (do_op && instr_op == MCAUX_OP_OFFS_COMP) begin
                offset_comp_en <= {instr_param[3], instr_param[3:0]};
            end
            if (do_op && instr_op == MCAUX_OP_GAIN) begin
                amp_gain <= instr_param[2:0];
            end
            if (do_op && instr_op == MCAUX_OP_CONV) begin
                conv_mode <= instr_param[0];
                compare_en <= ~instr_param[0];
            end
        end
    end

    // Backdoor sequencer: request and result capture both in the first cycle, the second only ends the access
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bd_state_reg <= MCAUX_BD_IDLE;
            bd_wr_reg <= 1'b0;
        end else begin
            case (bd_state_reg)
                MCAUX_BD_IDLE: begin
                    if (do_op && instr_op == MCAUX_OP_BD_READ) begin
                        bd_state_reg <= MCAUX_BD_REQ;
                        bd_wr_reg <= 1'b0;
                    end else if (do_op && instr_op == MCAUX_OP_BD_WRITE) begin
                        bd_state_reg <= MCAUX_BD_REQ;
                        bd_wr_reg <= 1'b1;
                    end
                end
                MCAUX_BD_REQ: bd_state_reg <= MCAUX_BD_DONE;
                default: bd_state_reg <= MCAUX_BD_IDLE;
            endcase
        end
    end

    // DAC and boost DAC targets are blocked; locked targets drop writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_req <= 1'b0;
            ext_wr <= 1'b0;
            ext_addr <= 8'h00;
            ext_wdata <= 16'h0000;
        end else begin
            ext_req <= bd_state_reg == MCAUX_BD_IDLE && do_op
                       && (instr_op == MCAUX_OP_BD_READ || instr_op == MCAUX_OP_BD_WRITE)
                       && !(bd_addr_reg >= `MCAUX_EXT_DAC_FIRST
                            && bd_addr_reg <= `MCAUX_EXT_DAC_LAST);
            ext_wr <= bd_state_reg == MCAUX_BD_IDLE && do_op
                      && instr_op == MCAUX_OP_BD_WRITE && !ext_locked
                      && !(bd_addr_reg >= `MCAUX_EXT_DAC_FIRST
                           && bd_addr_reg <= `MCAUX_EXT_DAC_LAST);
            ext_addr <= bd_addr_reg;
            ext_wdata <= bd_data_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bd_busy <= 1'b0;
        end else begin
            bd_busy <= (bd_state_reg == MCAUX_BD_IDLE && do_op
                        && (instr_op == MCAUX_OP_BD_READ || instr_op == MCAUX_OP_BD_WRITE))
                       || bd_state_reg == MCAUX_BD_REQ;
        end
    end

    // Plain storage whenever the backdoor is idle; a read that is not blocked overwrites data at the end of its first cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bd_addr_reg <= 8'h00;
            bd_data_reg <= 16'h0000;
        end else begin
            if (mm_wr && mm_addr == `MCAUX_ADDR_BD_ADDR) begin
                bd_addr_reg <= mm_wdata[7:0];
            end
            if (bd_state_reg == MCAUX_BD_REQ && !bd_wr_reg && ext_req) begin
                bd_data_reg <= ext_rdata;
            end else if (mm_wr && mm_addr == `MCAUX_ADDR_BD_DATA) begin
                bd_data_reg <= mm_wdata;
            end
        end
    end

    unlocked_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
        core_unlocked |=> own_flags_n == 16'hffff)
        else $error("unlocked core drives an active flag");
    irq_pin_a: assert property (@(posedge sys_clk) disable iff (rst)
        do_op && instr_op == MCAUX_OP_IRQ |-> ##2 interrupt_out_pin_n == !$past(instr_param[0], 2))
        else $error("interrupt pin does not follow the request");
    jsr_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        do_op && instr_op == MCAUX_OP_JSR && !mm_wr |=> aux_return == $past(program_counter))
        else $error("return point not captured");
    conv_compare_a: assert property (@(posedge sys_clk) disable iff (rst)
        conv_mode |-> !compare_en)
        else $error("threshold compare active in conversion mode");
    comp_link_a: assert property (@(posedge sys_clk) disable iff (rst)
        offset_comp_en[4] == offset_comp_en[3])
        else $error("high DAC compensation differs from low DAC");
    bd_two_cycle_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(bd_busy) |=> bd_busy ##1 !bd_busy)
        else $error("backdoor access is not two cycles");
    bd_locked_a: assert property (@(posedge sys_clk) disable iff (rst)
        do_op && instr_op == MCAUX_OP_BD_WRITE && ext_locked |=> !ext_wr)
        else $error("write issued to a locked register");
    bd_dac_block_a: assert property (@(posedge sys_clk) disable iff (rst)
        ext_req |-> !(ext_addr >= 8'h90 && ext_addr <= 8'h9b))
        else $error("backdoor reached a DAC register");
    dac_reserved_a: assert property (@(posedge sys_clk) disable iff (rst)
        (dac_threshold[0][15:14] == 2'h0) && (dac_high_neg_combined[15:12] == 4'h0))
        else $error("reserved DAC bits set");
    diag_set_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
        |diag_event |=> (diag_errors & $past(diag_event)) == $past(diag_event))
        else $error("diagnosis event lost");

endmodule // mcaux_top
`default_nettype wire

// file: hw/mcaux_pkg.sv
// Types shared by the microcore auxiliary functions block
`default_nettype none
package mcaux_pkg;

    typedef enum logic [3:0] {
        MCAUX_OP_NONE,
        MCAUX_OP_DAC_MODE,
        MCAUX_OP_SHARED_SEL,
        MCAUX_OP_REG_RESET,
        MCAUX_OP_DIAG_EN,
        MCAUX_OP_FLAG,
        MCAUX_OP_IRQ,
        MCAUX_OP_JSR,
        MCAUX_OP_OFFS_COMP,
        MCAUX_OP_GAIN,
        MCAUX_OP_CONV,
        MCAUX_OP_STAT_BIT,
        MCAUX_OP_BD_READ,
        MCAUX_OP_BD_WRITE
    } mcaux_op_e;

    typedef enum logic [1:0] {
        MCAUX_MODE_VALUE,
        MCAUX_MODE_OFFSET,
        MCAUX_MODE_FULL
    } mcaux_mode_e;

    typedef enum logic [1:0] {
        MCAUX_BD_IDLE,
        MCAUX_BD_REQ,
        MCAUX_BD_DONE
    } mcaux_bd_e;

endpackage
`default_nettype wire

// file: hw/mcaux_map.svh
// Internal address map, field masks and reset values of the auxiliary block
`ifndef MCAUX_MAP_SVH
`define MCAUX_MAP_SVH

`define MCAUX_ADDR_DAC0 8'h00
`define MCAUX_ADDR_DAC3 8'h03
`define MCAUX_ADDR_DAC4H4NEG 8'h04
`define MCAUX_ADDR_SHARED 8'h05
`define MCAUX_ADDR_STATUS 8'h06
`define MCAUX_ADDR_CTRL 8'h07
`define MCAUX_ADDR_BD_ADDR 8'h08
`define MCAUX_ADDR_BD_DATA 8'h09
`define MCAUX_ADDR_AUX 8'h0a
`define MCAUX_ADDR_DIAG 8'h0b

`define MCAUX_DAC_VALUE_MASK 16'h00ff
`define MCAUX_DAC_OFFSET_MASK 16'h3f00
`define MCAUX_DAC_FULL_MASK 16'h3fff
`define MCAUX_HN_HIGH_MASK 16'h00ff
`define MCAUX_HN_NEG_MASK 16'h0f00
`define MCAUX_HN_FULL_MASK 16'h0fff
`define MCAUX_ADC_MASK 16'h01ff

`define MCAUX_FLAGS_RESET 16'hffff
`define MCAUX_DAC_RESET 16'h0000

`define MCAUX_EXT_DAC_FIRST 8'h90
`define MCAUX_EXT_DAC_LAST 8'h9b

`define MCAUX_BD_CYCLES 2

`endif

// file: dv/mcaux_ext_model.sv
// Behavioural model of the external register space behind the backdoor
`timescale 1ns/100ps
`default_nettype none
module mcaux_ext_model (
    input wire logic sys_clk,
    input wire logic ext_req,
    input wire logic ext_wr,
    input wire logic [7:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    output logic [15:0] ext_rdata
);
    logic [15:0] mem [0:255];
    logic [15:0] junk_reg = 16'h0f0f;
    // Data only while requested; a moving pattern otherwise, so stale reads show up
    assign ext_rdata = ext_req ? mem[ext_addr] : junk_reg;
    always_ff @(posedge sys_clk) begin
        junk_reg <= ~junk_reg ^ 16'h0001;
        if (ext_req && ext_wr) begin
            mem[ext_addr] <= ext_wdata;
        end
    end
endmodule // mcaux_ext_model
`default_nettype wire

// file: dv/mcaux_top_bench.sv
// Self-checking testbench of the microcore auxiliary functions block
`timescale 1ns/100ps
`default_nettype none
module mcaux_top_bench;
    import mcaux_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0, mm_wr = 1'b0, mm_rd = 1'b0, core_unlocked = 1'b0, ext_locked = 1'b0;
    mcaux_op_e instr_op = MCAUX_OP_NONE;
    logic [15:0] instr_param = 16'h0000, mm_wdata = 16'h0000, diag_event = 16'h0000;
    logic [9:0] program_counter = 10'h000;
    logic [7:0] mm_addr = 8'h00, out_access = 8'h0f;
    logic [3:0][8:0] adc_result = '0;
    logic [3:0][15:0] shared_in = '0;
    logic [2:0][15:0] flags_other = {16'hffff, 16'hfffe, 16'hffff};
    logic [3:0] flag_combine_cfg = 4'hf;
    logic [15:0] mm_rdata, shx, own_f, mrg_f, stat, ctrl, derr, dhn, ext_wdata, ext_rdata;
    logic [3:0][15:0] dac;
    logic [9:0] aux;
    logic [7:0] den, ext_addr;
    logic [4:0] ocomp;
    logic [2:0] gain;
    logic irq_n, armed, conv, cmp_en, ext_req, ext_wr, busy;
    int n_errors = 0, n_tests = 0, n_req = 0;
    always #2 sys_clk = ~sys_clk;
    mcaux_top uut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_param(instr_param), .program_counter(program_counter),
        .core_unlocked(core_unlocked), .mm_wr(mm_wr), .mm_rd(mm_rd), .mm_addr(mm_addr),
        .mm_wdata(mm_wdata), .mm_rdata(mm_rdata), .adc_result(adc_result), .shared_in(shared_in),
        .shared_exchange_location(shx), .flags_other(flags_other),
        .flag_combine_cfg(flag_combine_cfg), .own_flags_n(own_f), .merged_flags_n(mrg_f),
        .interrupt_out_pin_n(irq_n), .aux_return(aux), .out_access(out_access),
        .diag_enable(den), .diag_event(diag_event), .diag_irq_armed(armed), .status_bits(stat),
        .ctrl_bits(ctrl), .diag_errors(derr), .dac_threshold(dac), .dac_high_neg_combined(dhn),
        .offset_comp_en(ocomp), .amp_gain(gain), .conv_mode(conv), .compare_en(cmp_en),
        .ext_req(ext_req), .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .ext_locked(ext_locked), .bd_busy(busy));
    mcaux_ext_model ext (.sys_clk(sys_clk), .ext_req(ext_req), .ext_wr(ext_wr),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
    always @(posedge sys_clk) if (ext_req === 1'b1) n_req++;
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic mm_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk) begin mm_wr <= 1'b1; mm_addr <= a; mm_wdata <= d; end
        @(posedge sys_clk) mm_wr <= 1'b0;
        #1;
    endtask
    task automatic mm_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk) begin mm_rd <= 1'b1; mm_addr <= a; end
        @(posedge sys_clk) mm_rd <= 1'b0;
        #1 check("map read", exp, mm_rdata);
    endtask
    task automatic instr(input mcaux_op_e op, input logic [15:0] p);
        @(posedge sys_clk) begin instr_valid <= 1'b1; instr_op <= op; instr_param <= p; end
        @(posedge sys_clk) instr_valid <= 1'b0;
        #1;
    endtask
    task automatic bd(input mcaux_op_e op);
        instr(op, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        #1 check("flags", 16'hffff, own_f);
        check("merged", 16'hffff, mrg_f);
        check("irq pin", 16'h0001, {15'h0, irq_n});
        check("compare", 16'h0001, {15'h0, cmp_en});
        $display("test reset done");
        // Full mode is the reset mode
        mm_write(8'h00, 16'hffff);
        mm_read(8'h00, 16'h3fff);
        instr(MCAUX_OP_DAC_MODE, 16'h0000);
        mm_write(8'h00, 16'h0012);
        mm_read(8'h00, 16'h0012);
        instr(MCAUX_OP_DAC_MODE, 16'h0001);
        mm_write(8'h00, 16'hc5ff);
        mm_read(8'h00, 16'h0500);
        check("dac0", 16'h0512, dac[0]);
        instr(MCAUX_OP_DAC_MODE, 16'h0002);
        mm_write(8'h04, 16'hffff);
        check("combined", 16'h0fff, dhn);
        instr(MCAUX_OP_DAC_MODE, 16'h0000);
        mm_write(8'h04, 16'h00aa);
        instr(MCAUX_OP_DAC_MODE, 16'h0001);
        mm_write(8'h04, 16'h0300);
        check("combined", 16'h03aa, dhn);
        $display("test dac modes done");
        @(posedge sys_clk) adc_result[1] <= 9'h1a5;
        instr(MCAUX_OP_DAC_MODE, 16'h0000);
        instr(MCAUX_OP_CONV, 16'h0001);
        check("conv", 16'h0000, {15'h0, cmp_en});
        check("conv mode", 16'h0001, {15'h0, conv});
        mm_read(8'h01, 16'h01a5);
        mm_read(8'h04, 16'h00aa);
        instr(MCAUX_OP_CONV, 16'h0000);
        check("conv mode", 16'h0000, {15'h0, conv});
        mm_read(8'h01, 16'h0000);
        $display("test conversion done");
        instr(MCAUX_OP_FLAG, 16'h0003);
        @(posedge sys_clk) #1 check("flags", 16'hfff7, own_f);
        // The merged bus is built from the registered own bus, one cycle later
        @(posedge sys_clk) #1 check("merged", 16'hfff6, mrg_f);
        @(posedge sys_clk) core_unlocked <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check("flags", 16'hffff, own_f);
        check("merged", 16'hfffe, mrg_f);
        instr(MCAUX_OP_IRQ, 16'h0001);
        @(posedge sys_clk) #1 check("irq pin", 16'h0000, {15'h0, irq_n});
        @(posedge sys_clk) program_counter <= 10'h2a5;
        instr(MCAUX_OP_JSR, 16'h0000);
        mm_read(8'h0a, 16'h02a5);
        instr(MCAUX_OP_DIAG_EN, 16'hffff);
        check("diag en", 16'h000f, {8'h0, den});
        instr(MCAUX_OP_OFFS_COMP, 16'h0008);
        check("offs comp", 16'h0018, {11'h0, ocomp});
        instr(MCAUX_OP_GAIN, 16'h0005);
        check("gain", 16'h0005, {13'h0, gain});
        $display("test controls done");
        mm_write(8'h06, 16'h1234);
        instr(MCAUX_OP_STAT_BIT, 16'h0010);
        check("status", 16'h1235, stat);
        for (int v = 0; v < 8; v++) begin
            mm_write(8'h06, 16'h00ff);
            mm_write(8'h07, 16'h00ff);
            @(posedge sys_clk) diag_event <= 16'h0001;
            @(posedge sys_clk) diag_event <= 16'h0000;
            instr(MCAUX_OP_REG_RESET, 16'(v));
            check("status", 8'h6d >> v & 1 ? 16'h0000 : 16'h00ff, stat);
            check("ctrl", 8'h2a >> v & 1 ? 16'h0000 : 16'h00ff, ctrl);
            check("diag", 8'h1c >> v & 1 ? 16'h0000 : 16'h0001, derr);
            check("armed", 8'hdc >> v & 1 ? 16'h0001 : 16'h0000, {15'h0, armed});
        end
        $display("test register reset done");
        mm_write(8'h05, 16'hbeef);
        check("shared out", 16'hbeef, shx);
        @(posedge sys_clk) shared_in[2] <= 16'h1357;
        instr(MCAUX_OP_SHARED_SEL, 16'h0002);
        mm_read(8'h05, 16'h1357);
        mm_write(8'h08, 16'h0012);
        mm_read(8'h08, 16'h0012);
        mm_write(8'h09, 16'hc0de);
        bd(MCAUX_OP_BD_WRITE);
        mm_write(8'h09, 16'h0000);
        bd(MCAUX_OP_BD_READ);
        mm_read(8'h09, 16'hc0de);
        @(posedge sys_clk) ext_locked <= 1'b1;
        mm_write(8'h09, 16'h1111);
        bd(MCAUX_OP_BD_WRITE);
        @(posedge sys_clk) ext_locked <= 1'b0;
        bd(MCAUX_OP_BD_READ);
        mm_read(8'h09, 16'hc0de);
        check("requests", 16'h0004, 16'(n_req));
        mm_write(8'h08, 16'h0090);
        mm_write(8'h09, 16'h5555);
        bd(MCAUX_OP_BD_READ);
        mm_read(8'h09, 16'h5555);
        check("requests", 16'h0004, 16'(n_req));
        $display("test backdoor done");
        report_and_stop;
    end
endmodule // mcaux_top_bench
`default_nettype wire
